//--- src/tfd_pkg.sv
/*
 Package for the task-file register decoder: layouts, offsets, field positions and buffer sizes.
 Assumes a single clock domain and host strobes already synchronous to it.
*/
package tfd_pkg;
    typedef enum logic [2:0] {
        TFD_MEM,
        TFD_IO_CONTIG,
        TFD_IO_PRIMARY,
        TFD_IO_SECONDARY,
        TFD_DISK_COMPAT
    } tfd_layout_t;

    localparam logic [2:0] SEL_MEM = 3'h0;
    localparam logic [2:0] SEL_IO_CONTIG = 3'h1;
    localparam logic [2:0] SEL_IO_PRIMARY = 3'h2;
    localparam logic [2:0] SEL_IO_SECONDARY = 3'h3;

    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_ERR_FEAT = 4'h1;
    localparam logic [3:0] OFS_SECT_TOTAL = 4'h2;
    localparam logic [3:0] OFS_START_SECT = 4'h3;
    localparam logic [3:0] OFS_TRACK_LOW = 4'h4;
    localparam logic [3:0] OFS_TRACK_HIGH = 4'h5;
    localparam logic [3:0] OFS_UNIT_SURF = 4'h6;
    localparam logic [3:0] OFS_STATE_OPCODE = 4'h7;
    localparam logic [3:0] OFS_MIRROR_EVEN = 4'h8;
    localparam logic [3:0] OFS_MIRROR_ODD = 4'h9;
    localparam logic [3:0] OFS_MIRROR_ERR = 4'hd;
    localparam logic [3:0] OFS_SHADOW_CTRL = 4'he;
    localparam logic [3:0] OFS_UNIT_ADDR = 4'hf;

    localparam logic [5:0] PRIMARY_TASK_BASE = 6'h1f;
    localparam logic [5:0] PRIMARY_ALT_BASE = 6'h3f;
    localparam logic [5:0] SECONDARY_TASK_BASE = 6'h17;
    localparam logic [5:0] SECONDARY_ALT_BASE = 6'h37;
    localparam logic [2:0] ALT_LOW_BITS = 3'h6;
    localparam logic [2:0] ADDR_LOW_BITS = 3'h7;

    localparam logic [7:0] ERR_READ_MASK = 8'hd5;
    localparam int ERR_BIT_BAD_BLOCK = 7;
    localparam int ERR_BIT_UNCORRECTABLE = 6;
    localparam int ERR_BIT_SECTOR_MISSING = 4;
    localparam int ERR_BIT_ABORTED = 2;
    localparam int ERR_BIT_GENERAL = 0;

    localparam logic [7:0] SECT_TOTAL_RESET = 8'h01;
    localparam logic [7:0] UNIT_SURF_RESET = 8'ha0;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_WIDTH = 16;
endpackage

//--- src/tfd_task_file.sv
/*
 Task-file address decoder and register bank with the sector data port and error register.
 Assumes the configuration selector, strobes and address arrive synchronous to clk_i and
 that a write strobe is held low for at least one clock; each access acts on its falling edge.
*/
`timescale 1ns/1ns
module tfd_task_file (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] config_selector_i,
    input wire logic disk_mode_i,
    input wire logic attr_select_n_i,
    input wire logic [10:0] addr_i,
    input wire logic output_enable_n_i,
    input wire logic write_enable_n_i,
    input wire logic io_read_strobe_n_i,
    input wire logic io_write_strobe_n_i,
    input wire logic chip_enable_low_n_i,
    input wire logic chip_enable_high_n_i,
    input wire logic [15:0] host_data_i,
    output logic [15:0] host_data_o,
    output logic host_data_oe_o,
    input wire logic [7:0] state_i,
    input wire logic [7:0] unit_address_i,
    input wire logic bad_block_flag_i,
    input wire logic uncorrectable_flag_i,
    input wire logic sector_missing_flag_i,
    input wire logic command_aborted_flag_i,
    input wire logic general_error_flag_i,
    input wire logic error_clear_i,
    output logic [15:0] write_word_o,
    output logic write_valid_o,
    input wire logic write_ready_i,
    input wire logic [15:0] read_word_i,
    input wire logic read_valid_i,
    output logic read_ready_o,
    output logic [7:0] feature_o,
    output logic [7:0] sector_total_o,
    output logic [7:0] start_sector_o,
    output logic [7:0] track_low_o,
    output logic [7:0] track_high_o,
    output logic [7:0] unit_surface_o,
    output logic [7:0] opcode_o,
    output logic opcode_valid_o,
    output logic [7:0] device_control_o,
    output logic write_stall_o
);
    import tfd_pkg::*;

    // Register index for a hit: offset code, plus a flag for a valid decode.
    typedef struct packed {
        logic hit;
        logic [3:0] ofs;
    } tfd_hit_t;

    // Both I/O block layouts share this decode; only the bases differ.
    function automatic tfd_hit_t decode_block(input logic [5:0] hi, input logic [3:0] lo,
                                              input logic [5:0] task_base, input logic [5:0] alt_base);
        tfd_hit_t r;
        r.hit = 1'b0;
        r.ofs = lo;
        if (hi == task_base && !lo[3]) begin
            r.hit = 1'b1;
        end else if (hi == alt_base && (lo[2:0] == ALT_LOW_BITS || lo[2:0] == ADDR_LOW_BITS) && !lo[3]) begin
            r.hit = 1'b1;
            r.ofs = {1'b1, lo[2:0]};
        end
        return r;
    endfunction

    function automatic logic mapped_low(input logic [3:0] lo);
        return !(lo > OFS_MIRROR_ODD && lo < OFS_MIRROR_ERR);
    endfunction

    tfd_layout_t layout;
    tfd_hit_t hit_primary;
    tfd_hit_t hit_secondary;
    tfd_hit_t sel;
    wire logic rd_n;
    wire logic wr_n;
    logic rd_q;
    logic wr_q;
    wire logic rd_start;
    wire logic wr_start;
    wire logic [3:0] ofs;
    wire logic byte_mode;
    wire logic word_ofs;
    wire logic even_ofs;
    wire logic odd_ofs;
    wire logic word_access;
    wire logic err_ofs;

    assign layout = disk_mode_i ? TFD_DISK_COMPAT :
                    (config_selector_i == SEL_MEM) ? TFD_MEM :
                    (config_selector_i == SEL_IO_CONTIG) ? TFD_IO_CONTIG :
                    (config_selector_i == SEL_IO_PRIMARY) ? TFD_IO_PRIMARY : TFD_IO_SECONDARY;
    assign hit_primary = decode_block(addr_i[9:4], addr_i[3:0], PRIMARY_TASK_BASE, PRIMARY_ALT_BASE);
    assign hit_secondary = decode_block(addr_i[9:4], addr_i[3:0], SECONDARY_TASK_BASE, SECONDARY_ALT_BASE);

    always_comb begin
        sel.hit = 1'b0;
        sel.ofs = addr_i[3:0];
        case (layout)
            TFD_MEM: begin
                sel.hit = attr_select_n_i && mapped_low(addr_i[3:0]);
                if (addr_i[10]) begin
                    sel.ofs = addr_i[0] ? OFS_MIRROR_ODD : OFS_MIRROR_EVEN;
                    sel.hit = attr_select_n_i;
                end
            end
            TFD_IO_CONTIG: begin
                sel.hit = !attr_select_n_i && mapped_low(addr_i[3:0]);
            end
            TFD_IO_PRIMARY: begin
                sel.hit = !attr_select_n_i && hit_primary.hit;
                sel.ofs = hit_primary.ofs;
            end
            TFD_IO_SECONDARY: begin
                sel.hit = !attr_select_n_i && hit_secondary.hit;
                sel.ofs = hit_secondary.ofs;
            end
            default: begin
                if (!chip_enable_low_n_i && chip_enable_high_n_i) begin
                    sel.hit = 1'b1;
                    sel.ofs = {1'b0, addr_i[2:0]};
                end else if (!chip_enable_high_n_i && chip_enable_low_n_i &&
                             (addr_i[2:0] == ALT_LOW_BITS || addr_i[2:0] == ADDR_LOW_BITS)) begin
                    sel.hit = 1'b1;
                    sel.ofs = {1'b1, addr_i[2:0]};
                end
            end
        endcase
    end

    // Memory mode uses output/write enables, every other layout the I/O strobes.
    assign rd_n = (layout == TFD_MEM) ? output_enable_n_i : io_read_strobe_n_i;
    assign wr_n = (layout == TFD_MEM) ? write_enable_n_i : io_write_strobe_n_i;
    // A held strobe acts once, on the first edge it is seen low.
    assign rd_start = !rd_n && !rd_q && sel.hit;
    assign wr_start = !wr_n && !wr_q && sel.hit;
    assign ofs = sel.ofs;
    // Byte access: the disk layout always works in words on the data port; elsewhere
    // chip_enable_high_n_i high marks an 8-bit cycle.
    assign byte_mode = (layout != TFD_DISK_COMPAT) && chip_enable_high_n_i;
    assign word_ofs = (ofs == OFS_DATA);
    assign even_ofs = (ofs == OFS_MIRROR_EVEN) || (word_ofs && byte_mode);
    assign odd_ofs = (ofs == OFS_MIRROR_ODD);
    assign word_access = word_ofs && !byte_mode;
    // The odd data byte never claims 1H, so that slot stays error/feature in every layout.
    assign err_ofs = (ofs == OFS_ERR_FEAT) || (ofs == OFS_MIRROR_ERR);

    // Two-entry write buffer toward the card.
    logic [BUF_WIDTH-1:0] wbuf_q [BUF_DEPTH];
    logic wptr_q;
    logic rptr_q;
    logic [1:0] wcnt_q;
    logic [7:0] low_hold_q;
    logic low_held_q;
    wire logic wbuf_full;
    wire logic push;
    wire logic pop;
    wire logic [15:0] push_word;
    assign wbuf_full = (wcnt_q == 2'(BUF_DEPTH));
    assign push_word = word_access ? host_data_i : {host_data_i[7:0], low_hold_q};
    assign push = wr_start && !wbuf_full && (word_access || (odd_ofs && low_held_q));
    assign pop = write_valid_o && write_ready_i;
    assign write_valid_o = (wcnt_q != 2'h0);
    assign write_word_o = wbuf_q[rptr_q];
    assign write_stall_o = wbuf_full;

    // Two-entry read buffer from the card.
    logic [BUF_WIDTH-1:0] rbuf_q [BUF_DEPTH];
    logic rwp_q;
    logic rrp_q;
    logic [1:0] rcnt_q;
    logic odd_next_q;
    wire logic rpush;
    wire logic rpop;
    wire logic [15:0] rhead;
    assign read_ready_o = (rcnt_q != 2'(BUF_DEPTH));
    assign rpush = read_valid_i && read_ready_o;
    assign rhead = rbuf_q[rrp_q];
    // An odd byte read pops the word only after its even half, as on the write side.
    assign rpop = rd_start && (rcnt_q != 2'h0) && (word_access || (odd_ofs && odd_next_q));

    // Error register, sticky per event, cleared by the command engine.
    logic [7:0] err_q;
    wire logic [7:0] err_set;
    assign err_set[ERR_BIT_BAD_BLOCK] = bad_block_flag_i;
    assign err_set[ERR_BIT_UNCORRECTABLE] = uncorrectable_flag_i;
    assign err_set[ERR_BIT_SECTOR_MISSING] = sector_missing_flag_i;
    assign err_set[ERR_BIT_ABORTED] = command_aborted_flag_i;
    assign err_set[ERR_BIT_GENERAL] = general_error_flag_i;
    // Bits 5, 3 and 1 have no source, so they always read zero.
    assign err_set[5] = 1'b0;
    assign err_set[3] = 1'b0;
    assign err_set[1] = 1'b0;

    wire logic wr_err = wr_start && err_ofs;
    // Per-register write strobes.
    wire logic wr_sect_total = wr_start && (ofs == OFS_SECT_TOTAL);
    wire logic wr_start_sect = wr_start && (ofs == OFS_START_SECT);
    wire logic wr_track_low = wr_start && (ofs == OFS_TRACK_LOW);
    wire logic wr_track_high = wr_start && (ofs == OFS_TRACK_HIGH);
    wire logic wr_unit_surf = wr_start && (ofs == OFS_UNIT_SURF);
    wire logic wr_opcode = wr_start && (ofs == OFS_STATE_OPCODE);
    wire logic wr_dev_ctrl = wr_start && (ofs == OFS_SHADOW_CTRL);
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (word_access) begin
            rd_mux = rhead;
        end else if (even_ofs) begin
            rd_mux = {8'h00, rhead[7:0]};
        end else if (odd_ofs) begin
            rd_mux = {8'h00, rhead[15:8]};
        end else if (err_ofs) begin
            rd_mux = {8'h00, err_q & ERR_READ_MASK};
        end else if (ofs == OFS_SECT_TOTAL) begin
            rd_mux = {8'h00, sector_total_o};
        end else if (ofs == OFS_START_SECT) begin
            rd_mux = {8'h00, start_sector_o};
        end else if (ofs == OFS_TRACK_LOW) begin
            rd_mux = {8'h00, track_low_o};
        end else if (ofs == OFS_TRACK_HIGH) begin
            rd_mux = {8'h00, track_high_o};
        end else if (ofs == OFS_UNIT_SURF) begin
            rd_mux = {8'h00, unit_surface_o};
        end else if (ofs == OFS_STATE_OPCODE || ofs == OFS_SHADOW_CTRL) begin
            rd_mux = {8'h00, state_i};
        end else if (ofs == OFS_UNIT_ADDR) begin
            rd_mux = {8'h00, unit_address_i};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            host_data_o <= 16'h0000;
            host_data_oe_o <= 1'b0;
        end else begin
            rd_q <= !rd_n;
            wr_q <= !wr_n;
            host_data_oe_o <= !rd_n && sel.hit;
            if (rd_start) begin
                host_data_o <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_q <= 8'h00;
        end else begin
            err_q <= err_set | (error_clear_i ? 8'h00 : err_q);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            feature_o <= 8'h00;
            sector_total_o <= SECT_TOTAL_RESET;
            start_sector_o <= 8'h00;
            track_low_o <= 8'h00;
            track_high_o <= 8'h00;
        end else begin
            if (wr_err) begin
                feature_o <= host_data_i[7:0];
            end else if (wr_sect_total) begin
                sector_total_o <= host_data_i[7:0];
            end else if (wr_start_sect) begin
                start_sector_o <= host_data_i[7:0];
            end else if (wr_track_low) begin
                track_low_o <= host_data_i[7:0];
            end else if (wr_track_high) begin
                track_high_o <= host_data_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unit_surface_o <= UNIT_SURF_RESET;
            opcode_o <= 8'h00;
            opcode_valid_o <= 1'b0;
            device_control_o <= 8'h00;
        end else begin
            opcode_valid_o <= wr_opcode;
            // Writes to the drive-address slot and to AH..CH fall through with no effect.
            if (wr_unit_surf) begin
                unit_surface_o <= host_data_i[7:0];
            end else if (wr_opcode) begin
                opcode_o <= host_data_i[7:0];
            end else if (wr_dev_ctrl) begin
                device_control_o <= host_data_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            wcnt_q <= 2'h0;
            low_hold_q <= 8'h00;
            low_held_q <= 1'b0;
        end else begin
            if (wr_start && even_ofs) begin
                low_hold_q <= host_data_i[7:0];
                low_held_q <= 1'b1;
            end else if (push) begin
                low_held_q <= 1'b0;
            end
            if (push) begin
                wptr_q <= !wptr_q;
            end
            if (pop) begin
                rptr_q <= !rptr_q;
            end
            wcnt_q <= wcnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // A full buffer drops the host word; write_stall_o tells the command engine to hold busy.
    always_ff @(posedge clk_i) begin
        if (push) begin
            wbuf_q[wptr_q] <= push_word;
        end
        if (rpush) begin
            rbuf_q[rwp_q] <= read_word_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rwp_q <= 1'b0;
            rrp_q <= 1'b0;
            rcnt_q <= 2'h0;
            odd_next_q <= 1'b0;
        end else begin
            if (rd_start && even_ofs) begin
                odd_next_q <= 1'b1;
            end else if (rpop) begin
                odd_next_q <= 1'b0;
            end
            if (rpush) begin
                rwp_q <= !rwp_q;
            end
            if (rpop) begin
                rrp_q <= !rrp_q;
            end
            rcnt_q <= rcnt_q + {1'b0, rpush} - {1'b0, rpop};
        end
    end
endmodule // tfd_task_file

//--- dv/tfd_task_file_monitor.sv
/*
 Checker for the task-file decoder, watching only the top module's ports.
 Assumes one clock domain and that the host holds address and data over each strobe.
*/
`timescale 1ns/1ns
module tfd_task_file_monitor (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] config_selector_i,
    input wire logic disk_mode_i,
    input wire logic attr_select_n_i,
    input wire logic [10:0] addr_i,
    input wire logic write_enable_n_i,
    input wire logic io_read_strobe_n_i,
    input wire logic io_write_strobe_n_i,
    input wire logic chip_enable_low_n_i,
    input wire logic chip_enable_high_n_i,
    input wire logic [15:0] host_data_i,
    input wire logic [15:0] host_data_o,
    input wire logic host_data_oe_o,
    input wire logic [7:0] state_i,
    input wire logic write_valid_o,
    input wire logic write_stall_o,
    input wire logic [7:0] feature_o,
    input wire logic [7:0] sector_total_o,
    input wire logic [7:0] track_low_o,
    input wire logic [7:0] unit_surface_o,
    input wire logic opcode_valid_o,
    input wire logic [7:0] device_control_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire io_on = !disk_mode_i && !attr_select_n_i;
    wire cio = io_on && config_selector_i == 3'h1;
    wire pri = io_on && config_selector_i == 3'h2;
    wire sec = io_on && config_selector_i == 3'h3;
    wire mem = !disk_mode_i && attr_select_n_i && config_selector_i == 3'h0 && !addr_i[10];
    a_cio_feature: assert property (cio && $fell(io_write_strobe_n_i) && addr_i[3:0] == 4'h1 |=>
        feature_o == $past(host_data_i[7:0])) else $error("feature write lost");
    a_word_push: assert property (cio && $fell(io_write_strobe_n_i) && addr_i[3:0] == 4'h0
        && !chip_enable_high_n_i && !write_stall_o |=> write_valid_o) else $error("data word not queued");
    a_opcode_pulse: assert property (cio && $fell(io_write_strobe_n_i) && addr_i[3:0] == 4'h7 |=>
        opcode_valid_o ##1 !opcode_valid_o) else $error("command pulse wrong");
    a_mem_dup_feat: assert property (mem && $fell(write_enable_n_i) && addr_i[3:0] == 4'hd |=>
        feature_o == $past(host_data_i[7:0])) else $error("mirror feature write lost");
    a_pri_total: assert property (pri && $fell(io_write_strobe_n_i) && addr_i[9:0] == 10'h1f2 |=>
        sector_total_o == $past(host_data_i[7:0])) else $error("primary count write lost");
    a_sec_track: assert property (sec && $fell(io_write_strobe_n_i) && addr_i[9:0] == 10'h174 |=>
        track_low_o == $past(host_data_i[7:0])) else $error("secondary track write lost");
    a_disk_ctrl: assert property (disk_mode_i && !chip_enable_high_n_i && chip_enable_low_n_i
        && addr_i[2:0] == 3'h6 && $fell(io_write_strobe_n_i) |=> device_control_o == $past(host_data_i[7:0]))
        else $error("disk control write lost");
    a_unmapped_hold: assert property (mem && $fell(write_enable_n_i) && addr_i[3:0] inside {4'ha, 4'hb, 4'hc}
        |=> $stable(feature_o) && $stable(sector_total_o) && $stable(track_low_o) && $stable(unit_surface_o)
        && $stable(device_control_o)) else $error("unmapped write changed a register");
    a_status_read: assert property (cio && $fell(io_read_strobe_n_i) && addr_i[3:0] == 4'h7 |=>
        host_data_o[7:0] == $past(state_i)) else $error("status read wrong");
    a_read_drives: assert property (cio && $fell(io_read_strobe_n_i) && addr_i[3:0] == 4'h7 |=>
        host_data_oe_o) else $error("read data not driven");
    a_err_zeros: assert property (cio && $fell(io_read_strobe_n_i) && addr_i[3:0] == 4'h1 |=>
        !host_data_o[5] && !host_data_o[3] && !host_data_o[1]) else $error("error zero bits set");
    c_word_write: cover property (cio && $fell(io_write_strobe_n_i) && addr_i[3:0] == 4'h0);
    c_buffer_full: cover property (write_stall_o);
    c_disk_read: cover property (disk_mode_i && $fell(io_read_strobe_n_i));
endmodule // tfd_task_file_monitor

//--- dv/tfd_host_model.sv
/*
 Host bus controller model: one register access per call, with layout-specific addressing.
 Assumes the design takes an access on the first edge with the strobe low.
*/
`timescale 1ns/1ns
module tfd_host_model (
    input wire logic clk_i,
    input wire logic [15:0] data_i,
    output logic [10:0] addr_o,
    output logic attr_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic io_read_strobe_n_n_o,
    output logic io_write_strobe_n_n_o,
    output logic ce_lo_n_o,
    output logic ce_hi_n_o,
    output logic [15:0] data_o
);
    initial {oe_n_o, we_n_o, io_read_strobe_n_n_o, io_write_strobe_n_n_o, ce_lo_n_o, ce_hi_n_o, attr_n_o, addr_o, data_o} = '1;
    task automatic access(input int lay, input bit wr, input bit byte_c, input logic [3:0] ofs,
                          input logic [15:0] wd, output logic [15:0] rd);
        logic [10:0] a;
        a = {7'h00, ofs};
        if (lay == 0) a[9:4] = 6'($urandom);
        if (lay == 0 && ofs[3:1] == 3'h4 && $urandom % 2 == 1) a = {1'b1, 9'($urandom), ofs[0]};
        if (lay == 1) a[10:4] = 7'($urandom);
        if (lay == 2 || lay == 3) a = {1'b0, (ofs[3] ? 6'h3f : 6'h1f) & (lay == 3 ? 6'h37 : 6'h3f), 1'b0, ofs[2:0]};
        if (lay == 4) a = {8'h00, ofs[2:0]};
        @(posedge clk_i);
        addr_o <= a;
        attr_n_o <= (lay == 0);
        ce_lo_n_o <= (lay == 4) && ofs[3];
        ce_hi_n_o <= (lay == 4) ? !ofs[3] : byte_c;
        data_o <= wd;
        if (lay == 0) {we_n_o, oe_n_o} <= wr ? 2'b01 : 2'b10;
        else {io_write_strobe_n_n_o, io_read_strobe_n_n_o} <= wr ? 2'b01 : 2'b10;
        repeat (3) @(posedge clk_i);
        rd = data_i;
        {oe_n_o, we_n_o, io_read_strobe_n_n_o, io_write_strobe_n_n_o} <= 4'hf;
        // Released data lines show the inverse so a stale value cannot pass.
        data_o <= ~wd;
    endtask
endmodule // tfd_host_model

//--- dv/task_file_register_decode_tb_top.sv
/*
 Self-checking testbench for the task-file decoder with a host model and a stream side.
 Assumes a 100 MHz clock and the access timing of the host model.
*/
`timescale 1ns/1ns
module task_file_register_decode_tb_top;
    logic clk_i = 0, resetn_i = 0, disk = 0, eclr = 0, wready = 0, rvalid = 0;
    logic [2:0] cfg = 0;
    logic [7:0] state = 0, uaddr = 0;
    logic [4:0] eflag = 0;
    logic [15:0] rword = 0, rd, v, w1, dout, hdata;
    logic [10:0] addr;
    logic attr_n, oe_n, we_n, io_read_strobe_n_n, io_write_strobe_n_n, ce_lo_n, ce_hi_n;
    wire [15:0] write_word_o;
    wire [7:0] feature_o, sector_total_o, start_sector_o, track_low_o, track_high_o, unit_surface_o, opcode_o;
    wire [7:0] device_control_o;
    wire write_valid_o, read_ready_o, opcode_valid_o, write_stall_o, oe;
    int failures = 0, check_count = 0, lay;
    int bits[5] = '{7, 6, 4, 2, 0};
    always #5 clk_i = ~clk_i;
    tfd_host_model host (.clk_i(clk_i), .data_i(dout), .addr_o(addr), .attr_n_o(attr_n), .oe_n_o(oe_n),
        .we_n_o(we_n), .io_read_strobe_n_n_o(io_read_strobe_n_n), .io_write_strobe_n_n_o(io_write_strobe_n_n), .ce_lo_n_o(ce_lo_n), .ce_hi_n_o(ce_hi_n),
        .data_o(hdata));
    tfd_task_file uut (.clk_i(clk_i), .resetn_i(resetn_i), .config_selector_i(cfg), .disk_mode_i(disk),
        .attr_select_n_i(attr_n), .addr_i(addr), .output_enable_n_i(oe_n), .write_enable_n_i(we_n),
        .io_read_strobe_n_i(io_read_strobe_n_n), .io_write_strobe_n_i(io_write_strobe_n_n), .chip_enable_low_n_i(ce_lo_n),
        .chip_enable_high_n_i(ce_hi_n), .host_data_i(hdata), .host_data_o(dout), .host_data_oe_o(oe),
        .state_i(state), .unit_address_i(uaddr), .bad_block_flag_i(eflag[0]), .uncorrectable_flag_i(eflag[1]),
        .sector_missing_flag_i(eflag[2]), .command_aborted_flag_i(eflag[3]), .general_error_flag_i(eflag[4]),
        .error_clear_i(eclr), .write_word_o(write_word_o), .write_valid_o(write_valid_o),
        .write_ready_i(wready), .read_word_i(rword), .read_valid_i(rvalid), .read_ready_o(read_ready_o),
        .feature_o(feature_o), .sector_total_o(sector_total_o), .start_sector_o(start_sector_o),
        .track_low_o(track_low_o), .track_high_o(track_high_o), .unit_surface_o(unit_surface_o),
        .opcode_o(opcode_o), .opcode_valid_o(opcode_valid_o), .device_control_o(device_control_o),
        .write_stall_o(write_stall_o));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rw(input bit wr, input logic [3:0] o, input logic [15:0] d, input bit b = 0);
        host.access(lay, wr, b, o, d, rd);
    endtask
    task automatic set_lay(input int l);
        lay = l;
        @(posedge clk_i);
        cfg <= 3'(l % 4);
        disk <= (l == 4);
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        void'($urandom(92806));
        repeat (6) @(posedge clk_i);
        resetn_i <= 1;
        @(posedge clk_i);
        #1 chk(sector_total_o, 16'h0001);
        chk(unit_surface_o, 16'h00a0);
        chk(read_ready_o, 16'h0001);
        chk(oe, 16'h0000);
        // Every layout writes and reads the same registers through its own decode.
        for (int l = 0; l < 5; l++) begin
            set_lay(l);
            v = 16'($urandom);
            rw(1, 4'h2, v); chk(sector_total_o, v[7:0]);
            rw(1, 4'h4, ~v); chk(track_low_o, 8'(~v));
            rw(1, 4'h6, v); chk(unit_surface_o, v[7:0]);
            rw(1, 4'h3, v); chk(start_sector_o, v[7:0]);
            rw(1, 4'h5, ~v); chk(track_high_o, 8'(~v));
            rw(0, 4'h2, 0); chk(rd[7:0], v[7:0]);
            rw(0, 4'h5, 0); chk(rd[7:0], 8'(~v));
            rw(1, 4'he, v); chk(device_control_o, v[7:0]);
            rw(1, 4'hf, ~v); chk(unit_surface_o, v[7:0]);
            chk(device_control_o, v[7:0]);
            @(posedge clk_i) state <= v[15:8];
            uaddr <= ~v[15:8];
            rw(0, 4'h7, 0); chk(rd[7:0], v[15:8]);
            rw(0, 4'he, 0); chk(rd[7:0], v[15:8]);
            rw(0, 4'hf, 0); chk(rd[7:0], 8'(~v[15:8]));
            rw(1, 4'h7, v); chk(opcode_o, v[7:0]);
            if (l < 2) begin
                rw(1, 4'hd, ~v); chk(feature_o, 8'(~v));
                rw(1, 4'ha, ~v); rw(1, 4'hc, ~v); chk(sector_total_o, v[7:0]);
            end
            $display("layout %0d done", l);
        end
        set_lay(1);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i) eclr <= 1;
            @(posedge clk_i) eclr <= 0;
            eflag <= (i < 5) ? 5'(1 << i) : 5'h1f;
            @(posedge clk_i) eflag <= 0;
            v = (i < 5) ? 16'(1 << bits[i]) : 16'h00d5;
            rw(0, 4'h1, 0); chk(rd[7:0], v[7:0]);
            rw(0, 4'hd, 0); chk(rd[7:0], v[7:0]);
        end
        rw(1, 4'h1, 16'h002a); chk(feature_o, 16'h002a);
        rw(0, 4'h1, 0); chk(rd[7:0], 8'hd5);
        $display("error register done");
        v = 16'($urandom);
        w1 = 16'($urandom);
        rw(1, 4'h0, v); chk(write_valid_o, 1); chk(write_word_o, v);
        rw(1, 4'h0, w1); chk(write_stall_o, 1);
        rw(1, 4'h0, ~w1);
        @(posedge clk_i) wready <= 1;
        @(posedge clk_i) wready <= 0;
        #1 chk(write_word_o, w1); chk(write_stall_o, 0);
        @(posedge clk_i) wready <= 1;
        @(posedge clk_i) wready <= 0;
        #1 chk(write_valid_o, 0);
        set_lay(0);
        rw(1, 4'h8, {2{v[7:0]}}, 1); rw(1, 4'h9, {2{w1[7:0]}}, 1);
        chk(write_word_o, {w1[7:0], v[7:0]});
        @(posedge clk_i) wready <= 1;
        @(posedge clk_i) wready <= 0;
        rword <= v;
        rvalid <= 1;
        @(posedge clk_i) rword <= w1;
        @(posedge clk_i) rvalid <= 0;
        rword <= ~w1;
        #1 chk(read_ready_o, 0);
        rw(0, 4'h0, 0); chk(rd, v);
        rw(0, 4'h8, 0, 1); chk(rd[7:0], w1[7:0]);
        rw(0, 4'h9, 0, 1); chk(rd[7:0], w1[15:8]);
        chk(read_ready_o, 1);
        $display("data path done");
        report_and_stop();
    end
endmodule // task_file_register_decode_tb_top
bind tfd_task_file tfd_task_file_monitor mon (.clk_i(clk_i), .resetn_i(resetn_i),
    .config_selector_i(config_selector_i), .disk_mode_i(disk_mode_i), .attr_select_n_i(attr_select_n_i),
    .addr_i(addr_i), .write_enable_n_i(write_enable_n_i), .io_read_strobe_n_i(io_read_strobe_n_i),
    .io_write_strobe_n_i(io_write_strobe_n_i), .chip_enable_low_n_i(chip_enable_low_n_i),
    .chip_enable_high_n_i(chip_enable_high_n_i), .host_data_i(host_data_i), .host_data_o(host_data_o),
    .state_i(state_i), .write_valid_o(write_valid_o), .write_stall_o(write_stall_o), .feature_o(feature_o),
    .sector_total_o(sector_total_o), .track_low_o(track_low_o), .unit_surface_o(unit_surface_o),
    .opcode_valid_o(opcode_valid_o), .device_control_o(device_control_o), .host_data_oe_o(host_data_oe_o));
